// ===== hw/timer2_pkg.sv
// package for the sixteen-bit timer with capture, reload and baud modes
// assumes one core clock and an sfr bus with byte-wide strobes
package timer2_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_TIMER_TWO_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE_LO = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE_HI = 8'hCB;
  localparam logic [7:0] ADDR_COUNTER_LOW       = 8'hCC;
  localparam logic [7:0] ADDR_COUNTER_HIGH      = 8'hCD;

  // ==========================================================
  // control register bit positions
  localparam int BIT_OVERFLOW_FLAG        = 7;
  localparam int BIT_EXTERNAL_EVENT_FLAG  = 6;
  localparam int BIT_RX_BAUD_SOURCE_SEL   = 5;
  localparam int BIT_TX_BAUD_SOURCE_SEL   = 4;
  localparam int BIT_TRIGGER_INPUT_ENABLE = 3;
  localparam int BIT_RUN_CONTROL          = 2;
  localparam int BIT_COUNT_SOURCE_SEL     = 1;
  localparam int BIT_CAPTURE_RELOAD_SEL   = 0;

  // ==========================================================
  // values after reset, counter limits and step, and the unmapped read value
  localparam logic [7:0]  RESET_CONTROL  = 8'h00;
  localparam logic [15:0] RESET_COUNTER  = 16'h0000;
  localparam logic [15:0] RESET_RELOAD   = 16'h0000;
  localparam logic [7:0]  RESET_RDATA    = 8'h00;
  localparam logic [15:0] COUNTER_TOP    = 16'hFFFF;
  localparam logic [15:0] COUNTER_WRAP   = 16'h0000;
  localparam logic [15:0] COUNTER_STEP   = 16'h0001;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_RELOAD,
    MODE_CAPTURE,
    MODE_BAUD
  } timer_mode_t;

  // ==========================================================
  // sfr request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // pin synchroniser state
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } pin_sync_t;

endpackage

// ===== hw/pin_sync_fall.sv
// two-flop synchroniser with falling-edge detect for one pin
// assumes the pin is asynchronous to sys_clk_i
`timescale 1ns/100ps
module pin_sync_fall
  import timer2_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // pin side
  input  wire logic pin_i,
  // core side
  output logic      level_o,
  output logic      fall_o
);

  // ==========================================================
  // state
  pin_sync_t state;
  pin_sync_t next_state;

  always_comb
  begin
    next_state      = state;
    next_state.meta = pin_i;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1};
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // one sample high then one sample low
  assign level_o = state.sync;
  assign fall_o  = state.prev & ~state.sync;

endmodule

// ===== hw/timer2_capture_reload_baud.sv
// sixteen-bit timer/counter with reload, capture and baud modes
// assumes the core reaches registers over the sfr strobes below
// and the serial port takes one-cycle baud ticks on its clock
`timescale 1ns/100ps
module timer2_capture_reload_baud
  import timer2_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // sfr access from the core
  input  wire sfr_req_t   sfr_req_i,
  output logic     [7:0]  sfr_rdata_o,
  // external pins
  input  wire logic       count_input_pin_i,
  input  wire logic       trigger_input_pin_i,
  // timer 1 overflow from the same clock
  input  wire logic       timer1_ovf_i,
  // serial port baud clocks
  output logic            rx_baud_tick_o,
  output logic            tx_baud_tick_o,
  output logic            overflow_tick_o,
  // interrupt request
  output logic            irq_o
);

  // ==========================================================
  // state of the block
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] count;
    logic [15:0] reload;
    logic [7:0]  rdata;
    logic        tick;
  } timer_state_t;

  timer_state_t state;
  timer_state_t next_state;

  // ==========================================================
  // mode decode
  function automatic timer_mode_t decode_mode(input logic [7:0] ctrl);
    timer_mode_t m;
    m = MODE_OFF;
    if (!ctrl[BIT_RUN_CONTROL])
    begin
      m = MODE_OFF;
    end
    else if (ctrl[BIT_RX_BAUD_SOURCE_SEL] | ctrl[BIT_TX_BAUD_SOURCE_SEL])
    begin
      m = MODE_BAUD;
    end
    else if (ctrl[BIT_CAPTURE_RELOAD_SEL])
    begin
      m = MODE_CAPTURE;
    end
    else
    begin
      m = MODE_RELOAD;
    end
    return m;
  endfunction

  // ==========================================================
  // sfr helpers
  function automatic logic write_hit(input sfr_req_t   req,
                                     input logic [7:0] addr);
    return req.wr & (req.addr == addr);
  endfunction

  // one byte of a sixteen-bit pair, high or low
  function automatic logic [15:0] with_byte(input logic [15:0] word,
                                            input logic        upper,
                                            input logic [7:0]  value);
    logic [15:0] w;
    w = word;
    if (upper)
    begin
      w[15:8] = value;
    end
    else
    begin
      w[7:0] = value;
    end
    return w;
  endfunction

  // byte seen by a read of one sfr address
  function automatic logic [7:0] read_byte(input logic [7:0]   addr,
                                           input timer_state_t s);
    logic [7:0] b;
    b = UNMAPPED_READ;
    unique case (addr)
      ADDR_TIMER_TWO_CONTROL:
      begin
        b = s.ctrl;
      end
      ADDR_RELOAD_CAPTURE_LO:
      begin
        b = s.reload[7:0];
      end
      ADDR_RELOAD_CAPTURE_HI:
      begin
        b = s.reload[15:8];
      end
      ADDR_COUNTER_LOW:
      begin
        b = s.count[7:0];
      end
      ADDR_COUNTER_HIGH:
      begin
        b = s.count[15:8];
      end
      default:
      begin
        b = UNMAPPED_READ;
      end
    endcase
    return b;
  endfunction

  // ==========================================================
  // pin synchronisers
  logic count_fall;
  logic trig_fall;

  pin_sync_fall u_count_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (count_input_pin_i),
    .level_o   (),
    .fall_o    (count_fall)
  );

  pin_sync_fall u_trig_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (trigger_input_pin_i),
    .level_o   (),
    .fall_o    (trig_fall)
  );

  // ==========================================================
  // event decode
  timer_mode_t mode;
  logic        run;
  logic        advance;
  logic        rollover;
  logic        trig_seen;
  logic        trig_reload;
  logic        trig_capture;
  logic        rx_sel;
  logic        tx_sel;
  logic        baud_sel;
  logic        set_overflow;
  logic        set_external;

  assign mode   = decode_mode(state.ctrl);
  assign run    = state.ctrl[BIT_RUN_CONTROL];
  assign rx_sel = state.ctrl[BIT_RX_BAUD_SOURCE_SEL];
  assign tx_sel = state.ctrl[BIT_TX_BAUD_SOURCE_SEL];

  // core clock or pin events, gated by run
  always_comb
  begin
    advance = 1'b0;
    if (run)
    begin
      if (state.ctrl[BIT_COUNT_SOURCE_SEL])
      begin
        advance = count_fall;
      end
      else
      begin
        advance = 1'b1;
      end
    end
  end

  assign rollover = advance & (state.count == COUNTER_TOP);

  // trigger edge while enabled and running
  assign trig_seen = trig_fall
                   & state.ctrl[BIT_TRIGGER_INPUT_ENABLE]
                   & run;

  // baud mode keeps the flag but drops the load
  assign trig_reload  = trig_seen & (mode == MODE_RELOAD);
  assign trig_capture = trig_seen & (mode == MODE_CAPTURE);

  // baud mode rollovers leave the overflow flag alone
  assign baud_sel     = rx_sel | tx_sel;
  assign set_overflow = rollover & ~baud_sel;
  assign set_external = trig_seen;

  // ==========================================================
  // register writes
  logic wr_ctrl;
  logic wr_rcap_lo;
  logic wr_rcap_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;

  assign wr_ctrl    = write_hit(sfr_req_i, ADDR_TIMER_TWO_CONTROL);
  assign wr_rcap_lo = write_hit(sfr_req_i, ADDR_RELOAD_CAPTURE_LO);
  assign wr_rcap_hi = write_hit(sfr_req_i, ADDR_RELOAD_CAPTURE_HI);
  assign wr_cnt_lo  = write_hit(sfr_req_i, ADDR_COUNTER_LOW);
  assign wr_cnt_hi  = write_hit(sfr_req_i, ADDR_COUNTER_HIGH);

  // ==========================================================
  // next state
  always_comb
  begin
    next_state      = state;
    next_state.tick = rollover;

    // control register, flags set by hardware win
    if (wr_ctrl)
    begin
      next_state.ctrl = sfr_req_i.wdata;
    end
    if (set_overflow)
    begin
      next_state.ctrl[BIT_OVERFLOW_FLAG] = 1'b1;
    end
    if (set_external)
    begin
      next_state.ctrl[BIT_EXTERNAL_EVENT_FLAG] = 1'b1;
    end

    // counter: hardware update first, byte writes override
    if (trig_reload)
    begin
      next_state.count = state.reload;
    end
    else if (rollover)
    begin
      unique case (mode)
        MODE_RELOAD:
        begin
          next_state.count = state.reload;
        end
        MODE_BAUD:
        begin
          next_state.count = state.reload;
        end
        MODE_CAPTURE:
        begin
          next_state.count = COUNTER_WRAP;
        end
        MODE_OFF:
        begin
          next_state.count = state.count;
        end
      endcase
    end
    else if (advance)
    begin
      next_state.count = state.count + COUNTER_STEP;
    end
    if (wr_cnt_lo)
    begin
      next_state.count = with_byte(next_state.count, 1'b0, sfr_req_i.wdata);
    end
    if (wr_cnt_hi)
    begin
      next_state.count = with_byte(next_state.count, 1'b1, sfr_req_i.wdata);
    end

    // reload pair: software write, capture wins
    if (wr_rcap_lo)
    begin
      next_state.reload = with_byte(next_state.reload, 1'b0, sfr_req_i.wdata);
    end
    if (wr_rcap_hi)
    begin
      next_state.reload = with_byte(next_state.reload, 1'b1, sfr_req_i.wdata);
    end
    if (trig_capture)
    begin
      next_state.reload[7:0]  = state.count[7:0];
      next_state.reload[15:8] = state.count[15:8];
    end

    // read data, registered on the read strobe
    if (sfr_req_i.rd)
    begin
      next_state.rdata = read_byte(sfr_req_i.addr, state);
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state.ctrl   <= RESET_CONTROL;
      state.count  <= RESET_COUNTER;
      state.reload <= RESET_RELOAD;
      state.rdata  <= RESET_RDATA;
      state.tick   <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign sfr_rdata_o     = state.rdata;
  assign overflow_tick_o = state.tick;

  // baud source selection
  assign rx_baud_tick_o = rx_sel ? state.tick : timer1_ovf_i;
  assign tx_baud_tick_o = tx_sel ? state.tick : timer1_ovf_i;

  // either flag requests service
  assign irq_o = state.ctrl[BIT_OVERFLOW_FLAG]
               | state.ctrl[BIT_EXTERNAL_EVENT_FLAG];

endmodule

// ===== tb/timer2_monitor.sv
// checker for the timer, watching the top-level ports only
// assumes one clock domain and the sfr strobe contract
`timescale 1ns/100ps
module timer2_monitor
  import timer2_pkg::*;
(
  // clock, reset, sfr
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire sfr_req_t   sfr_req_i,
  input  wire logic [7:0] sfr_rdata_o,
  // pins and ticks
  input  wire logic       count_input_pin_i,
  input  wire logic       trigger_input_pin_i,
  input  wire logic       timer1_ovf_i,
  input  wire logic       rx_baud_tick_o,
  input  wire logic       tx_baud_tick_o,
  input  wire logic       overflow_tick_o,
  input  wire logic       irq_o
);
  // ====
  // helpers
  logic ctl_wr;
  logic ctl_seen;
  assign ctl_wr = sfr_req_i.wr && (sfr_req_i.addr == ADDR_TIMER_TWO_CONTROL);
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
      ctl_seen <= 1'b0;
    else if (ctl_wr)
      ctl_seen <= 1'b1;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence ctl_write_s;
    ctl_wr;
  endsequence
  sequence ctl_read_s;
    sfr_req_i.rd && (sfr_req_i.addr == ADDR_TIMER_TWO_CONTROL);
  endsequence
  // ====
  // assertions
  rdata_hold_a: assert property (
    !sfr_req_i.rd |=> $stable(sfr_rdata_o)) else $error("read data moved");
  unmapped_read_a: assert property (
    sfr_req_i.rd && !(sfr_req_i.addr inside {8'hC8, [8'hCA:8'hCD]})
    |=> sfr_rdata_o == UNMAPPED_READ) else $error("unmapped read not zero");
  ctrl_readback_a: assert property (
    ctl_write_s ##1 ctl_read_s |=> sfr_rdata_o[5:0] == $past(sfr_req_i.wdata[5:0], 2))
    else $error("control readback wrong");
  rx_source_a: assert property (
    !overflow_tick_o && !timer1_ovf_i |-> !rx_baud_tick_o) else $error("stray rx tick");
  tx_source_a: assert property (
    !overflow_tick_o && !timer1_ovf_i |-> !tx_baud_tick_o) else $error("stray tx tick");
  irq_sticky_a: assert property (
    irq_o && !ctl_wr |=> irq_o) else $error("irq dropped alone");
  irq_cause_a: assert property (
    $rose(irq_o) |-> overflow_tick_o || !$past(trigger_input_pin_i) || $past(ctl_wr))
    else $error("irq without cause");
  idle_quiet_a: assert property (
    !ctl_seen |-> !overflow_tick_o && !irq_o) else $error("activity while off");
  flag_read_a: assert property (
    ctl_read_s |=> (sfr_rdata_o[7:6] != 2'b00) == $past(irq_o)) else $error("flags vs irq");
endmodule

bind timer2_capture_reload_baud timer2_monitor mon_u (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .count_input_pin_i(count_input_pin_i),
  .trigger_input_pin_i(trigger_input_pin_i), .timer1_ovf_i(timer1_ovf_i),
  .rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o),
  .overflow_tick_o(overflow_tick_o), .irq_o(irq_o));

// ===== tb/core_uart_model.sv
// partner: timer 1 overflow every eight cycles, counts serial ticks
// assumes the bench pulses clr_i to open a counting window
`timescale 1ns/100ps
module core_uart_model
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // bench and serial side
  input  wire logic       clr_i,
  input  wire logic       rx_tick_i,
  input  wire logic       tx_tick_i,
  output logic            t1_ovf_o,
  output logic      [7:0] rx_n_o,
  output logic      [7:0] tx_n_o
);
  logic [2:0] div;
  assign t1_ovf_o = (div == 3'h7);
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      div    <= 3'h0;
      rx_n_o <= 8'h00;
      tx_n_o <= 8'h00;
    end
    else
    begin
      div    <= div + 3'h1;
      rx_n_o <= clr_i ? 8'h00 : rx_n_o + {7'h0, rx_tick_i};
      tx_n_o <= clr_i ? 8'h00 : tx_n_o + {7'h0, tx_tick_i};
    end
endmodule

// ===== tb/timer2_capture_reload_baud_tb.sv
// bench for the timer, reaching registers through the sfr strobes
// assumes the partner model makes timer 1 ticks and counts baud ticks
`timescale 1ns/100ps
module timer2_capture_reload_baud_tb
  import timer2_pkg::*;
;
  logic       sys_clk_i, nrst_i, cnt_pin, trg_pin, t1_ovf, clr;
  logic       rx_tick, tx_tick, ovf_tick, irq;
  logic [7:0] rdata, rx_n, tx_n;
  sfr_req_t   req;
  int         fail_count, compares, n;

  timer2_capture_reload_baud dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .sfr_req_i(req), .sfr_rdata_o(rdata), .count_input_pin_i(cnt_pin),
    .trigger_input_pin_i(trg_pin), .timer1_ovf_i(t1_ovf), .rx_baud_tick_o(rx_tick),
    .tx_baud_tick_o(tx_tick), .overflow_tick_o(ovf_tick), .irq_o(irq));
  core_uart_model uart_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clr_i(clr),
    .rx_tick_i(rx_tick), .tx_tick_i(tx_tick), .t1_ovf_o(t1_ovf), .rx_n_o(rx_n),
    .tx_n_o(tx_n));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ====
  // bus and pin tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    req = '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, 1'b1, a, 8'h00);
    @(negedge sys_clk_i);
    req.rd = 1'b0;
    chk(rdata, e);
  endtask
  task automatic pulse(input logic trig);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge sys_clk_i);
    clr = 1'b1;
    trg_pin = !trig;
    cnt_pin = trig;
    @(negedge sys_clk_i);
    clr = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    trg_pin = 1'b1;
    cnt_pin = 1'b1;
    repeat (5) @(negedge sys_clk_i);
  endtask

  // ====
  // scenarios
  task automatic t_off;
    rd(8'hC8, 8'h00);
    rd(8'hC9, 8'h00);
    pulse(1'b0);
    rd(8'hCC, 8'h00);
  endtask
  task automatic t_reload;
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h06);
    pulse(1'b0);
    rd(8'hCC, 8'h34);
    rd(8'hCD, 8'h12);
    rd(8'hC8, 8'h86);
    chk({7'h0, irq}, 8'h01);
    wr(8'hC8, 8'h06);
    rd(8'hC8, 8'h06);
    chk({7'h0, irq}, 8'h00);
  endtask
  task automatic t_trigger;
    wr(8'hCC, 8'h05);
    wr(8'hCD, 8'h00);
    pulse(1'b1);
    rd(8'hCC, 8'h05);
    rd(8'hC8, 8'h06);
    wr(8'hC8, 8'h0E);
    pulse(1'b1);
    rd(8'hCC, 8'h34);
    rd(8'hC8, 8'h4E);
  endtask
  task automatic t_capture;
    wr(8'hC8, 8'h0F);
    wr(8'hCC, 8'hCD);
    wr(8'hCD, 8'hAB);
    pulse(1'b1);
    rd(8'hCA, 8'hCD);
    rd(8'hCB, 8'hAB);
    rd(8'hC8, 8'h4F);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    pulse(1'b0);
    rd(8'hCC, 8'h00);
    rd(8'hC8, 8'hCF);
  endtask
  task automatic t_baud;
    wr(8'hC8, 8'h3F);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    pulse(1'b0);
    rd(8'hCC, 8'hCD);
    rd(8'hC8, 8'h3F);
    chk(rx_n, 8'h01);
    chk(tx_n, 8'h01);
    wr(8'hCC, 8'h01);
    wr(8'hCD, 8'h00);
    pulse(1'b1);
    rd(8'hCC, 8'h01);
    rd(8'hC8, 8'h7F);
    chk({7'h0, irq}, 8'h01);
    wr(8'hC8, 8'h26);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    pulse(1'b0);
    chk(rx_n, 8'h01);
    // eight counted cycles hold exactly one timer 1 tick
    chk(tx_n, 8'h01);
    pulse(1'b1);
    chk(rx_n, 8'h00);
    chk(tx_n, 8'h01);
    wr(8'hC8, 8'h16);
    pulse(1'b1);
    chk(rx_n, 8'h01);
    chk(tx_n, 8'h00);
  endtask
  task automatic t_clock;
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'hF0);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    for (n = 1; n < 40; n++)
    begin
      #1;
      if (ovf_tick === 1'b1)
        break;
      @(posedge sys_clk_i);
    end
    chk(n[7:0], 8'h10);
    rd(8'hC8, 8'h84);
  endtask

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    summarize();
  end

  initial
  begin
    nrst_i = 1'b0;
    cnt_pin = 1'b1;
    trg_pin = 1'b1;
    clr = 1'b0;
    req = '0;
    fail_count = 0;
    compares = 0;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    nrst_i = 1'b1;
    t_off();
    t_reload();
    t_trigger();
    t_capture();
    t_baud();
    t_clock();
    summarize();
  end
endmodule
